/* File: src/hall_speed_direction_encoder.sv */
`timescale 1ns/1ps
// Operation
// - One clock drives signal processing and the output encoder.
// - Uncalibrated: output held at low current, no pulses.
// - Uncalibrated: steps count only above noise constant; rising slopes issue triggers.
// - Self-calibration completes after two input transitions.
// - Offset is the mean of captured minimum and maximum, driven to DAC.
// - Calibrated offset update needs two extremes and matching slope direction.
// - Offset updates neither cause nor wait for output switching.
// - Gain chosen from amplitude and offset; noise constant follows gain.
// - Calibrated: switch at adaptive threshold, one pulse per rising edge.
// - Amplitudes below minimum detection limit cause no switching.
// - Hysteresis follows gain; smaller signals cause no switching.
// - Speed-only pulse first, and when input exceeds 1 kHz.
// - Left pulse for motion from supply pin toward ground pin.
// - Right pulse for motion from ground pin toward supply pin.
// - At each crossing subtract direction sample from stored one, then store.
// - Direction from difference sign combined with rising or falling edge.
// - First pulse after power-up is always speed-only.
// - Vibration: small speed amplitude, small direction, or alternating direction.
// - Vibration suppression only in calibrated mode.
// - High current is on, low is off; pulse length codes speed and direction.
// - Works from standstill up to 12 kHz input.
module hall_speed_direction_encoder
  import hall_pkg::*;
#(
  parameter int SPEED_ONLY_PERIOD = SPEED_ONLY_PERIOD_CYC
)
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic sample_valid_i,
  input wire logic signed [SAMPLE_W-1:0] speed_sample_i,
  input wire logic signed [SAMPLE_W-1:0] dir_sample_i,
  output logic signed [SAMPLE_W-1:0] offset_dac_o,
  output logic [1:0] gain_sel_o,
  output logic calibrated_o,
  output logic uncal_trigger_o,
  output logic vibration_o,
  output logic current_high_o
);

  cal_mode_e mode;
  logic signed [SAMPLE_W-1:0] track;
  logic slope_up;
  logic slope_known;
  logic [SAMPLE_W-1:0] noise;
  logic signed [SAMPLE_W-1:0] max_val;
  logic signed [SAMPLE_W-1:0] min_val;
  logic have_max;
  logic have_min;
  logic [1:0] ext_cnt;
  logic mag_high;
  logic signed [SAMPLE_W-1:0] dir_store;
  logic dir_have;
  logic dir_valid;
  logic last_left;
  logic first_done;
  logic [PERIOD_W-1:0] period_cnt;

  logic signed [SAMPLE_W:0] delta;
  logic signed [SAMPLE_W:0] noise_s;
  logic step_up;
  logic step_dn;
  logic peak_found;
  logic valley_found;
  logic ext_event;
  logic pair_ok;
  logic signed [SAMPLE_W-1:0] new_max;
  logic signed [SAMPLE_W-1:0] new_min;
  logic signed [SAMPLE_W:0] sum_new;
  logic signed [SAMPLE_W-1:0] mean_new;
  logic [SAMPLE_W:0] level;
  logic [1:0] next_gain;
  logic signed [SAMPLE_W:0] hyst_s;
  logic signed [SAMPLE_W:0] corr;
  logic signed [SAMPLE_W:0] amp_now;
  logic big_enough;
  logic rise_x;
  logic fall_x;
  logic signed [SAMPLE_W:0] diff_now;
  logic [SAMPLE_W:0] abs_diff;
  logic left_now;
  logic alt_now;
  logic vib_now;
  logic fast;
  logic cal_done;

  pulse_if pif ();

  // ==========================================================
  // Slope tracking with noise constant
  assign noise_s = $signed({1'b0, noise});
  assign delta = speed_sample_i - track;
  assign step_up = delta > noise_s;
  assign step_dn = delta < -noise_s;
  assign peak_found = sample_valid_i && step_dn && slope_known && slope_up;
  assign valley_found = sample_valid_i && step_up && slope_known && !slope_up;
  assign ext_event = peak_found || valley_found;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      track <= '0;
      slope_up <= 1'b0;
      slope_known <= 1'b0;
    end
    else if (sample_valid_i && (step_up || step_dn))
    begin
      track <= speed_sample_i;
      slope_up <= step_up;
      slope_known <= 1'b1;
    end
  end

  // Trigger on the first rising slope and on each later one while uncalibrated
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      uncal_trigger_o <= 1'b0;
    else
      uncal_trigger_o <= mode == PH_UNCAL && sample_valid_i && step_up && (!slope_known || !slope_up);
  end

  // ==========================================================
  // Peak detection
  assign new_max = peak_found ? track : max_val;
  assign new_min = valley_found ? track : min_val;
  assign sum_new = new_max + new_min;
  assign mean_new = sum_new[SAMPLE_W:1];
  assign pair_ok = (have_max || peak_found) && (have_min || valley_found);
  assign level = (SAMPLE_W+1)'(new_max - new_min) + (mean_new < 0 ? (SAMPLE_W+1)'(-mean_new)
    : (SAMPLE_W+1)'(mean_new));

  always_comb
  begin
    if (level >= GAIN_LEVEL_HI)
      next_gain = 2'h0;
    else if (level >= GAIN_LEVEL_MID)
      next_gain = 2'h1;
    else if (level >= GAIN_LEVEL_LO)
      next_gain = 2'h2;
    else
      next_gain = 2'h3;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      max_val <= '0;
      min_val <= '0;
      have_max <= 1'b0;
      have_min <= 1'b0;
      ext_cnt <= '0;
    end
    else if (ext_event)
    begin
      max_val <= new_max;
      min_val <= new_min;
      have_max <= have_max || peak_found;
      have_min <= have_min || valley_found;
      if (ext_cnt != CAL_TRANSITIONS)
        ext_cnt <= ext_cnt + 2'h1;
    end
  end

  // ==========================================================
  // Mode, gain and offset
  assign cal_done = mode == PH_UNCAL && ext_event && ext_cnt == CAL_TRANSITIONS - 2'h1 && pair_ok;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mode <= PH_UNCAL;
      gain_sel_o <= '0;
      noise <= INITIAL_NOISE_CONSTANT;
    end
    else if (cal_done)
    begin
      mode <= PH_CAL;
      gain_sel_o <= next_gain;
      noise <= GAIN_NOISE_CONSTANT[next_gain];
    end
  end

  assign calibrated_o = mode == PH_CAL;

  // Driven from the slope tracker, not the comparator, so it never couples to the output
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      offset_dac_o <= '0;
    else if (cal_done)
      offset_dac_o <= mean_new;
    else if (mode == PH_CAL && pair_ok && ((valley_found && mean_new > offset_dac_o)
      || (peak_found && mean_new < offset_dac_o)))
      offset_dac_o <= mean_new;
  end

  // ==========================================================
  // Calibrated switching with adaptive hysteresis
  assign hyst_s = $signed({1'b0, GAIN_HYSTERESIS[gain_sel_o]});
  assign corr = speed_sample_i - offset_dac_o;
  assign amp_now = max_val - min_val;
  assign big_enough = amp_now >= $signed({1'b0, MIN_DETECT_AMPLITUDE}) && amp_now >= hyst_s;
  // Decided per sample with no pipeline, so any rate up to the top input frequency is followed
  assign rise_x = mode == PH_CAL && sample_valid_i && !mag_high && corr > (hyst_s >>> 1) && big_enough;
  assign fall_x = mode == PH_CAL && sample_valid_i && mag_high && corr < -(hyst_s >>> 1);

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      mag_high <= 1'b0;
    else if (rise_x)
      mag_high <= 1'b1;
    else if (fall_x)
      mag_high <= 1'b0;
  end

  // ==========================================================
  // Direction
  assign diff_now = dir_store - dir_sample_i;
  assign abs_diff = diff_now < 0 ? (SAMPLE_W+1)'(-diff_now) : (SAMPLE_W+1)'(diff_now);
  assign left_now = (diff_now > 0) ^ fall_x;
  assign alt_now = dir_valid && dir_have && left_now != last_left;
  assign vib_now = mode == PH_CAL && (amp_now < hyst_s || (dir_have && abs_diff < {1'b0, DIR_LIMIT})
    || alt_now);

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      dir_store <= '0;
      dir_have <= 1'b0;
      dir_valid <= 1'b0;
      last_left <= 1'b0;
    end
    else if (rise_x || fall_x)
    begin
      dir_store <= dir_sample_i;
      dir_have <= 1'b1;
      if (dir_have)
      begin
        dir_valid <= 1'b1;
        last_left <= left_now;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      vibration_o <= 1'b0;
    else if (rise_x)
      vibration_o <= vib_now;
  end

  // ==========================================================
  // Input period for the speed-only limit
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      period_cnt <= '1;
    else if (rise_x)
      period_cnt <= '0;
    else if (period_cnt != '1)
      period_cnt <= period_cnt + 17'h0_0001;
  end

  assign fast = period_cnt < SPEED_ONLY_PERIOD;

  // ==========================================================
  // Pulse request
  assign pif.req = rise_x && !vib_now;
  assign pif.kind = (!first_done || !dir_valid || fast) ? PULSE_SPEED
    : (left_now ? PULSE_LEFT : PULSE_RIGHT);

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      first_done <= 1'b0;
    else if (pif.req && !pif.busy)
      first_done <= 1'b1;
  end

  // Same clock as the front end, no crossing needed
  pulse_encoder u_encoder (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .pif(pif.enc),
    .current_high_o(current_high_o)
  );

  // ==========================================================
  // Checks
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  AST_UNCAL_LOW: assert property (mode == PH_UNCAL |-> !pif.req && !current_high_o)
    else $error("output active while uncalibrated");
  AST_CAL_AFTER_TWO: assert property (ext_cnt == CAL_TRANSITIONS |-> calibrated_o)
    else $error("calibration not done after two transitions");
  AST_OFFSET_MEAN: assert property (cal_done |=> offset_dac_o == $past(mean_new))
    else $error("offset is not the extreme mean");
  AST_OFFSET_SLOPE: assert property ($past(mode) == PH_CAL && offset_dac_o > $past(offset_dac_o)
    |-> $past(valley_found))
    else $error("positive offset update outside rising slope");
  AST_NOISE_GAIN: assert property (mode == PH_CAL |-> noise == GAIN_NOISE_CONSTANT[gain_sel_o])
    else $error("noise constant does not follow gain");
  AST_SMALL_NO_SWITCH: assert property (amp_now < hyst_s |-> !rise_x)
    else $error("switching below hysteresis");
  AST_FIRST_SPEED: assert property (pif.req && !first_done |-> pif.kind == PULSE_SPEED)
    else $error("first pulse not speed-only");
  AST_FAST_SPEED: assert property (pif.req && fast |-> pif.kind == PULSE_SPEED)
    else $error("fast input without speed-only pulse");
  AST_VIB_BLOCK: assert property (rise_x && vib_now |=> vibration_o ##1 !current_high_o
    || $past(current_high_o))
    else $error("vibration did not suppress pulse");

  COV_CALIBRATE: cover property (cal_done);
  COV_LEFT: cover property (pif.req && !pif.busy && pif.kind == PULSE_LEFT);
  COV_RIGHT: cover property (pif.req && !pif.busy && pif.kind == PULSE_RIGHT);
  COV_VIBRATION: cover property (rise_x && alt_now);

endmodule : hall_speed_direction_encoder

/* File: src/hall_pkg.sv */
package hall_pkg;

  // ==========================================================
  // Data path
  localparam int SAMPLE_W = 10;
  localparam int PERIOD_W = 17;
  localparam int PULSE_W = 16;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int SPEED_ONLY_LIMIT_HZ = 1000;
  localparam int SPEED_ONLY_PERIOD_US = 1_000_000 / SPEED_ONLY_LIMIT_HZ;
  localparam int SPEED_ONLY_PERIOD_CYC = SPEED_ONLY_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int MAX_INPUT_HZ = 12000;
  // Longest pulse must end inside the shortest input period
  localparam int MIN_INPUT_PERIOD_CYC = CLK_HZ / MAX_INPUT_HZ;

  // ==========================================================
  // Calibration
  localparam logic [1:0] CAL_TRANSITIONS = 2'h2;
  localparam logic [SAMPLE_W-1:0] INITIAL_NOISE_CONSTANT = 10'h004;
  localparam logic [SAMPLE_W-1:0] MIN_DETECT_AMPLITUDE = 10'h010;
  localparam logic [SAMPLE_W-1:0] DIR_LIMIT = 10'h008;
  localparam logic [SAMPLE_W:0] GAIN_LEVEL_HI = 11'h200;
  localparam logic [SAMPLE_W:0] GAIN_LEVEL_MID = 11'h100;
  localparam logic [SAMPLE_W:0] GAIN_LEVEL_LO = 11'h080;
  localparam logic [SAMPLE_W-1:0] GAIN_NOISE_CONSTANT [4] = '{10'h010, 10'h008, 10'h004, 10'h002};
  localparam logic [SAMPLE_W-1:0] GAIN_HYSTERESIS [4] = '{10'h040, 10'h020, 10'h010, 10'h008};

  // ==========================================================
  // Output pulse lengths in clock cycles
  localparam logic [PULSE_W-1:0] PULSE_SPEED_CYC = 16'h0190;
  localparam logic [PULSE_W-1:0] LEFT_TURN_PULSE_CYC = 16'h0320;
  localparam logic [PULSE_W-1:0] RIGHT_TURN_PULSE_CYC = 16'h0640;

  typedef enum logic [1:0] {PULSE_SPEED, PULSE_LEFT, PULSE_RIGHT} pulse_kind_e;
  typedef enum logic {PH_UNCAL, PH_CAL} cal_mode_e;

endpackage : hall_pkg

/* File: src/pulse_if.sv */
`timescale 1ns/1ps
interface pulse_if;
  import hall_pkg::*;
  logic req;
  pulse_kind_e kind;
  logic busy;
  modport src (output req, output kind, input busy);
  modport enc (input req, input kind, output busy);
endinterface : pulse_if

/* File: src/pulse_encoder.sv */
`timescale 1ns/1ps
module pulse_encoder
  import hall_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  pulse_if.enc pif,
  output logic current_high_o
);

  logic [PULSE_W-1:0] remain;
  logic [PULSE_W-1:0] next_len;

  // ==========================================================
  // Length select
  always_comb
  begin
    case (pif.kind)
      PULSE_LEFT: next_len = LEFT_TURN_PULSE_CYC;
      PULSE_RIGHT: next_len = RIGHT_TURN_PULSE_CYC;
      default: next_len = PULSE_SPEED_CYC;
    endcase
  end

  assign pif.busy = current_high_o;

  // ==========================================================
  // High current for the pulse, low supply current otherwise
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      current_high_o <= 1'b0;
      remain <= '0;
    end
    else if (pif.req && !pif.busy)
    begin
      current_high_o <= 1'b1;
      remain <= next_len - 16'h0001;
    end
    else if (current_high_o)
    begin
      if (remain == '0)
        current_high_o <= 1'b0;
      else
        remain <= remain - 16'h0001;
    end
  end

  // ==========================================================
  // Checks
  logic [PULSE_W-1:0] width;
  logic [PULSE_W-1:0] expect_len;

  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      width <= '0;
      expect_len <= '0;
    end
    else
    begin
      width <= current_high_o ? width + 16'h0001 : '0;
      if (pif.req && !pif.busy)
        expect_len <= next_len;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  AST_PULSE_LENGTH: assert property ($fell(current_high_o) |-> width == expect_len)
    else $error("pulse width differs from selected length");
  AST_PULSE_START: assert property (pif.req && !pif.busy |=> current_high_o ##1 current_high_o)
    else $error("accepted request did not raise current");

endmodule : pulse_encoder

/* File: tb/pulse_meter.sv */
`timescale 1ns/1ps
// ==========================================================
// Far-end controller: times each high-current pulse in clocks
module pulse_meter
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic current_high_i,
  output logic [7:0] pulse_count_o,
  output logic [15:0] last_width_o
);
  logic [15:0] width;

  // Width is latched on the falling edge only, so a pulse cut short still shows
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      width <= '0;
      pulse_count_o <= '0;
      last_width_o <= '0;
    end
    else if (current_high_i)
    begin
      width <= width + 16'h0001;
    end
    else if (width != 16'h0000)
    begin
      last_width_o <= width;
      pulse_count_o <= pulse_count_o + 8'h01;
      width <= '0;
    end
  end
endmodule : pulse_meter

/* File: tb/test_hall_speed_direction_encoder.sv */
`timescale 1ns/1ps
module test_hall_speed_direction_encoder;
  import hall_pkg::*;
  localparam int SPEED_ONLY_SIM = 200;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic signed [SAMPLE_W-1:0] speed_sample_i = '0;
  logic signed [SAMPLE_W-1:0] dir_sample_i = '0;
  logic signed [SAMPLE_W-1:0] offset_dac_o;
  logic [1:0] gain_sel_o;
  logic calibrated_o;
  logic uncal_trigger_o;
  logic vibration_o;
  logic current_high_o;
  logic [7:0] pulse_count;
  logic [15:0] last_width;
  logic vib_seen = 1'b0;
  logic [7:0] trig_count = 8'h00;
  logic hi_seen = 1'b0;
  logic [7:0] cnt_before;
  int bad_count = 0;
  int cmp_count = 0;

  hall_speed_direction_encoder #(.SPEED_ONLY_PERIOD(SPEED_ONLY_SIM)) hall_speed_direction_encoder_inst (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sample_valid_i(sample_valid_i),
    .speed_sample_i(speed_sample_i), .dir_sample_i(dir_sample_i), .offset_dac_o(offset_dac_o),
    .gain_sel_o(gain_sel_o), .calibrated_o(calibrated_o), .uncal_trigger_o(uncal_trigger_o),
    .vibration_o(vibration_o), .current_high_o(current_high_o));

  pulse_meter pulse_meter_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .current_high_i(current_high_o), .pulse_count_o(pulse_count), .last_width_o(last_width));

  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ==========================================================
  // Sticky monitors; vib_seen is cleared by the scenarios, trig_count and hi_seen never are
  always @(posedge clk_sys_i)
  begin
    if (vibration_o === 1'b1)
      vib_seen <= 1'b1;
    if (uncal_trigger_o === 1'b1)
      trig_count <= trig_count + 8'h01;
    if (current_high_o === 1'b1)
      hi_seen <= 1'b1;
  end

  // ==========================================================
  // Compare and drive tasks
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_flag

  task automatic put(input int spd, input int dir, input int gap);
    @(negedge clk_sys_i);
    sample_valid_i = 1'b1;
    speed_sample_i = SAMPLE_W'(spd);
    dir_sample_i = SAMPLE_W'(dir);
    @(negedge clk_sys_i);
    sample_valid_i = 1'b0;
    repeat (gap) @(negedge clk_sys_i);
  endtask : put

  // Low then high sample; d > 0 gives left motion, d < 0 right
  task automatic wave(input int n, input int ctr, input int amp, input int d, input int gap);
    for (int i = 0; i < n; i++)
    begin
      put(ctr - amp, d, gap);
      put(ctr + amp, -d, gap);
    end
  endtask : wave

  task automatic stop_test();
    $display("counts: compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Scenarios
  task automatic test_reset();
    check_val(16'(offset_dac_o), 16'h0000);
    check_val(16'(gain_sel_o), 16'h0000);
    check_flag(calibrated_o, 1'b0);
    check_flag(current_high_o, 1'b0);
    check_flag(uncal_trigger_o, 1'b0);
    check_flag(vibration_o, 1'b0);
    $display("done: reset");
  endtask : test_reset

  task automatic test_calibrate();
    int n;
    put(0, 0, 2);
    put(3, 0, 2);
    put(0, 0, 2);
    put(3, 0, 2);
    check_val(16'(trig_count), 16'h0000);
    put(40, -50, 2);
    put(240, -50, 2);
    check_val(16'(trig_count), 16'h0001);
    put(40, 50, 2);
    put(-160, 50, 2);
    check_flag(calibrated_o, 1'b0);
    put(40, -50, 0);
    n = 0;
    while (calibrated_o !== 1'b1 && n < 4)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n == 4)
    begin
      bad_count++;
      stop_test();
    end
    check_flag(calibrated_o, 1'b1);
    check_val(16'(offset_dac_o), 16'h0028);
    check_val(16'(gain_sel_o), 16'h0001);
    check_flag(hi_seen, 1'b0);
    $display("done: calibrate");
  endtask : test_calibrate

  task automatic test_left();
    wave(1, 40, 200, 50, 1000);
    check_val(16'(pulse_count), 16'h0001);
    check_val(16'(trig_count), 16'h0002);
    check_val(last_width, PULSE_SPEED_CYC);
    wave(3, 40, 200, 50, 1000);
    check_val(last_width, LEFT_TURN_PULSE_CYC);
    check_flag(vibration_o, 1'b0);
    $display("done: left");
  endtask : test_left

  task automatic test_right();
    vib_seen = 1'b0;
    wave(4, 40, 200, -50, 1000);
    check_val(last_width, RIGHT_TURN_PULSE_CYC);
    check_flag(vib_seen, 1'b1);
    check_flag(vibration_o, 1'b0);
    $display("done: right");
  endtask : test_right

  task automatic test_fast();
    wave(30, 40, 200, 50, 40);
    repeat (2000) @(negedge clk_sys_i);
    check_val(last_width, PULSE_SPEED_CYC);
    $display("done: fast");
  endtask : test_fast

  task automatic test_small();
    cnt_before = pulse_count;
    wave(4, 40, 10, 50, 1000);
    check_val(16'(pulse_count), 16'(cnt_before));
    $display("done: small");
  endtask : test_small

  task automatic test_no_dir();
    // Flush the direction value stored by the earlier motion before counting
    wave(2, 40, 200, 0, 1000);
    vib_seen = 1'b0;
    cnt_before = pulse_count;
    wave(4, 40, 200, 0, 1000);
    check_val(16'(pulse_count), 16'(cnt_before));
    check_flag(vib_seen, 1'b1);
    $display("done: no_dir");
  endtask : test_no_dir

  task automatic test_offset();
    cnt_before = pulse_count;
    wave(4, 140, 200, 50, 1000);
    check_flag(offset_dac_o > 10'sd40, 1'b1);
    check_flag(offset_dac_o <= 10'sd140, 1'b1);
    check_flag(pulse_count != cnt_before, 1'b1);
    $display("done: offset");
  endtask : test_offset

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    test_reset();
    test_calibrate();
    test_left();
    test_right();
    test_fast();
    test_small();
    test_no_dir();
    test_offset();
    stop_test();
  end
endmodule : test_hall_speed_direction_encoder
